/* File: rtl/qss_top.sv */
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "qss_consts.svh"
module qss_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        link_clk,
  input  wire logic        dma_tx_done,
  input  wire logic        dma_rx_done,
  input  wire logic        desc_done,
  input  wire logic        desc_last,
  output logic             dma_close,
  output logic             spi_cs_n
);

  qss_link_if lnk ();

  qss_pkg::qss_run_e run_q;
  qss_pkg::qss_run_e run_d;

  logic                dp_wr_q;
  logic                dp_rd_q;
  logic [7:0]          dp_addr_q;
  logic                go_q;
  logic                pend_q;
  logic                issue;
  logic [5:0]          ctrl_q;
  qss_pkg::qss_cnt_t   len_q;
  qss_pkg::qss_cnt_t   done_cnt_q;
  qss_pkg::qss_cnt_t   tx_cnt_q;
  qss_pkg::qss_cnt_t   rx_cnt_q;
  logic                xfer_q;
  logic                dma_q;
  logic                ovf_q;
  logic                tx_seen_q;
  logic                rx_seen_q;
  logic                tgl_s;
  logic                tgl_old_q;
  logic                busy_s;
  logic                accept;
  logic                wr_ctrl;
  logic                wr_len;
  logic                wr_stat;
  logic                wr_tx;
  logic                rd_rx;
  logic                byte_evt;
  logic                tx_full;
  logic                dma_en;
  logic                manual;
  logic                len_hit;
  logic                tx_ok;
  logic                rx_ok;
  logic                dma_set;
  logic                xfer_set;
  logic                halt_done;
  logic                push;
  logic                pop_tx;
  logic [31:0]         rd_mux;

  // Write-one-clear with set winning over a clear in the same cycle
  function automatic logic w1c(input logic cur,
                               input logic clr,
                               input logic set);
    w1c = (cur & ~clr) | set;
  endfunction : w1c

  // Saturating count step shared by both buffer counters
  function automatic qss_pkg::qss_cnt_t step(
      input qss_pkg::qss_cnt_t cnt,
      input logic              inc,
      input logic              dec,
      input qss_pkg::qss_cnt_t top);
    step = cnt;
    if (inc && !dec && cnt != top) begin
      step = cnt + 16'h0001;
    end else if (dec && !inc && cnt != 16'h0000) begin
      step = cnt - 16'h0001;
    end
  endfunction : step

  assign lnk.go = go_q;

  qss_link_shift u_link (
    .link_clk (link_clk),
    .hresetn  (hresetn),
    .lnk      (lnk.link),
    .spi_cs_n (spi_cs_n)
  );

  qss_sync u_tgl_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (lnk.byte_tgl),
    .q     (tgl_s)
  );

  qss_sync u_busy_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (lnk.busy),
    .q     (busy_s)
  );

  // AHB-Lite slave: writes need no wait, reads take one
  assign accept = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q   <= 1'b0;
      dp_rd_q   <= 1'b0;
      dp_addr_q <= 8'h00;
    end else begin
      dp_wr_q <= accept & hwrite;
      dp_rd_q <= accept & ~hwrite;
      if (accept) begin
        dp_addr_q <= haddr[7:0];
      end
    end
  end

  // Read data sampled a cycle late so a write just before is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (accept && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (dp_rd_q) begin
        hreadyout <= 1'b1;
        hrdata    <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (dp_addr_q)
      `QSS_OFF_CTRL: begin
        rd_mux[5:0] = ctrl_q;
      end
      `QSS_OFF_LEN: begin
        rd_mux[15:0] = len_q;
      end
      `QSS_OFF_STAT: begin
        rd_mux[`QSS_ST_XFER]   = xfer_q;
        rd_mux[`QSS_ST_DMA]    = dma_q;
        rd_mux[`QSS_ST_OVF]    = ovf_q;
        rd_mux[`QSS_ST_TXFULL] = tx_full;
      end
      `QSS_OFF_CNT: begin
        rd_mux[31:`QSS_CNT_RX_LSB] = rx_cnt_q;
        rd_mux[15:0]               = tx_cnt_q;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  assign wr_ctrl = dp_wr_q & (dp_addr_q == `QSS_OFF_CTRL);
  assign wr_len  = dp_wr_q & (dp_addr_q == `QSS_OFF_LEN);
  assign wr_stat = dp_wr_q & (dp_addr_q == `QSS_OFF_STAT);
  assign wr_tx   = dp_wr_q & (dp_addr_q == `QSS_OFF_TXWR);
  assign rd_rx   = dp_rd_q & (dp_addr_q == `QSS_OFF_RXRD);

  // Start is a strobe and never stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `QSS_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q                 <= hwdata[5:0];
      ctrl_q[`QSS_CTL_START] <= 1'b0;
    end else if (halt_done) begin
      ctrl_q[`QSS_CTL_HALT] <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      len_q <= `QSS_LEN_RST;
    end else if (wr_len) begin
      len_q <= hwdata[15:0];
    end
  end

  assign dma_en = ctrl_q[`QSS_CTL_TXDMA] | ctrl_q[`QSS_CTL_RXDMA];
  assign manual = ~dma_en & ~ctrl_q[`QSS_CTL_DESC];

  // Byte completion arrives as a toggle from the link clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgl_old_q <= 1'b0;
    end else begin
      tgl_old_q <= tgl_s;
    end
  end

  assign byte_evt = tgl_s ^ tgl_old_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_cnt_q <= `QSS_CNT_RST;
    end else if (run_q == qss_pkg::QSS_IDLE) begin
      done_cnt_q <= `QSS_CNT_RST;
    end else if (byte_evt) begin
      done_cnt_q <= done_cnt_q + 16'h0001;
    end
  end

  assign len_hit = byte_evt & (done_cnt_q + 16'h0001 == len_q);

  // Buffer occupancy; the data store itself lives elsewhere
  assign tx_full = (tx_cnt_q == `QSS_TX_DEPTH);
  assign push    = wr_tx & ~tx_full;
  assign pop_tx  = byte_evt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_cnt_q <= `QSS_CNT_RST;
      rx_cnt_q <= `QSS_CNT_RST;
    end else begin
      tx_cnt_q <= step(tx_cnt_q, push, pop_tx, `QSS_TX_DEPTH);
      rx_cnt_q <= step(rx_cnt_q, byte_evt, rd_rx, `QSS_RX_DEPTH);
    end
  end

  // DMA done may come per direction on different cycles
  assign tx_ok = ~ctrl_q[`QSS_CTL_TXDMA] | tx_seen_q | dma_tx_done;
  assign rx_ok = ~ctrl_q[`QSS_CTL_RXDMA] | rx_seen_q | dma_rx_done;
  assign dma_set = dma_en & (dma_tx_done | dma_rx_done)
                 & tx_ok & rx_ok;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_seen_q <= 1'b0;
      rx_seen_q <= 1'b0;
    end else if (dma_set || !dma_en) begin
      tx_seen_q <= 1'b0;
      rx_seen_q <= 1'b0;
    end else begin
      tx_seen_q <= tx_seen_q | dma_tx_done;
      rx_seen_q <= rx_seen_q | dma_rx_done;
    end
  end

  // Closing the DMA transfer once the length is reached
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_close <= 1'b0;
    end else begin
      dma_close <= dma_en & ctrl_q[`QSS_CTL_CLOSE] & len_hit;
    end
  end

  // Halt waits for the byte asked for and a quiet link
  assign halt_done = (run_q == qss_pkg::QSS_HALT) & ~pend_q
                   & ~busy_s;

  always_comb begin
    xfer_set = halt_done;
    if (manual) begin
      xfer_set = xfer_set | len_hit;
    end else if (ctrl_q[`QSS_CTL_DESC]) begin
      xfer_set = xfer_set | (desc_done & desc_last);
    end else begin
      xfer_set = xfer_set | dma_set;
    end
  end

  always_comb begin
    run_d = run_q;
    unique case (run_q)
      qss_pkg::QSS_IDLE: begin
        if (wr_ctrl && hwdata[`QSS_CTL_START]) begin
          run_d = qss_pkg::QSS_RUN;
        end
      end
      qss_pkg::QSS_RUN: begin
        if (ctrl_q[`QSS_CTL_HALT]) begin
          run_d = qss_pkg::QSS_HALT;
        end else if (xfer_set) begin
          run_d = qss_pkg::QSS_IDLE;
        end
      end
      qss_pkg::QSS_HALT: begin
        if (halt_done) begin
          run_d = qss_pkg::QSS_IDLE;
        end
      end
      default: begin
        run_d = qss_pkg::QSS_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= qss_pkg::QSS_IDLE;
    end else begin
      run_q <= run_d;
    end
  end

  // One toggle per byte; no overrun of an empty buffer, nor past length when manual or close is set
  assign issue = (run_q == qss_pkg::QSS_RUN) & ~ctrl_q[`QSS_CTL_HALT]
               & (tx_cnt_q != 16'h0000) & ~pend_q
               & ~((manual | ctrl_q[`QSS_CTL_CLOSE])
                   & (done_cnt_q == len_q));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go_q   <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      go_q   <= go_q ^ issue;
      pend_q <= issue | (pend_q & ~byte_evt);
    end
  end

  // Status flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_q <= 1'b0;
      dma_q  <= 1'b0;
      ovf_q  <= 1'b0;
    end else begin
      xfer_q <= w1c(xfer_q, wr_stat & hwdata[`QSS_ST_XFER],
                    xfer_set);
      dma_q  <= w1c(dma_q, wr_stat & hwdata[`QSS_ST_DMA],
                    dma_set);
      ovf_q  <= w1c(ovf_q, wr_stat & hwdata[`QSS_ST_OVF],
                    wr_tx & tx_full);
    end
  end

  wire unused_ok = &{1'b0, hsize, haddr[31:8], htrans[0]};

endmodule : qss_top

/* File: common/qss_consts.svh */
`ifndef QSS_CONSTS_SVH
`define QSS_CONSTS_SVH
`define QSS_OFF_CTRL    8'h00
`define QSS_OFF_LEN     8'h04
`define QSS_OFF_STAT    8'h10
`define QSS_OFF_CNT     8'h14
`define QSS_OFF_TXWR    8'h20
`define QSS_OFF_RXRD    8'h24
`define QSS_CTL_TXDMA   0
`define QSS_CTL_RXDMA   1
`define QSS_CTL_DESC    2
`define QSS_CTL_CLOSE   3
`define QSS_CTL_START   4
`define QSS_CTL_HALT    5
`define QSS_ST_XFER     0
`define QSS_ST_DMA      1
`define QSS_ST_OVF      2
`define QSS_ST_TXFULL   8
`define QSS_CNT_RX_LSB  16
`define QSS_TX_DEPTH    16'h0008
`define QSS_RX_DEPTH    16'h0008
`define QSS_LAST_BIT    3'h7
`define QSS_CTRL_RST    6'h00
`define QSS_LEN_RST     16'h0000
`define QSS_CNT_RST     16'h0000
`endif

/* File: common/qss_pkg.sv */
package qss_pkg;
  typedef enum logic [1:0] {
    QSS_IDLE = 2'h0,
    QSS_RUN  = 2'h1,
    QSS_HALT = 2'h3
  } qss_run_e;
  typedef logic [15:0] qss_cnt_t;
endpackage : qss_pkg

/* File: common/qss_link_if.sv */
`timescale 1ns/10ps
interface qss_link_if;
  logic go;
  logic busy;
  logic byte_tgl;
  modport bus (
    output go,
    input  busy,
    input  byte_tgl
  );
  modport link (
    input  go,
    output busy,
    output byte_tgl
  );
endinterface : qss_link_if

/* File: rtl/qss_sync.sv */
`timescale 1ns/10ps
module qss_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : qss_sync

/* File: rtl/qss_link_shift.sv */
`timescale 1ns/10ps
module qss_link_shift (
  input  wire logic  link_clk,
  input  wire logic  hresetn,
  qss_link_if.link   lnk,
  output logic       spi_cs_n
);
  logic       go_s;
  logic       go_old_q;
  logic       req;
  logic       act_q;
  logic [2:0] bit_q;

  qss_sync u_go_sync (
    .clk   (link_clk),
    .rst_n (hresetn),
    .d     (lnk.go),
    .q     (go_s)
  );

  // Each toggle of go asks for exactly one byte
  assign req = go_s ^ go_old_q;

  // A byte once begun always runs to its eighth bit
  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) begin
      go_old_q     <= 1'b0;
      act_q        <= 1'b0;
      bit_q        <= 3'h0;
      lnk.byte_tgl <= 1'b0;
    end else begin
      go_old_q <= go_s;
      if (act_q) begin
        bit_q <= bit_q + 3'h1;
        if (bit_q == `QSS_LAST_BIT) begin
          lnk.byte_tgl <= ~lnk.byte_tgl;
          act_q        <= 1'b0;
        end
      end else if (req) begin
        act_q <= 1'b1;
        bit_q <= 3'h0;
      end
    end
  end

  // Busy covers a request seen but not yet begun
  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) begin
      lnk.busy <= 1'b0;
      spi_cs_n <= 1'b1;
    end else begin
      lnk.busy <= req | act_q;
      spi_cs_n <= ~(req | act_q);
    end
  end
endmodule : qss_link_shift

/* File: tb/qss_status_monitor.sv */
`timescale 1ns/10ps
module qss_status_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        link_clk,
  input wire logic        dma_close,
  input wire logic        spi_cs_n
);
  sequence s_rd_req;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_wr_req;
    hsel && htrans[1] && hready && hwrite;
  endsequence
  sequence s_rd_ans;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_read_wait;
    @(posedge hclk) disable iff (!hresetn) s_rd_req |=> s_rd_ans;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read answer not after one wait");
  property p_write_nowait;
    @(posedge hclk) disable iff (!hresetn) s_wr_req |=> hreadyout;
  endproperty
  a_write_nowait: assert property (p_write_nowait)
    else $error("write was stalled");
  property p_okay;
    @(posedge hclk) disable iff (!hresetn) hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay)
    else $error("response not okay");
  property p_one_wait;
    @(posedge hclk) disable iff (!hresetn) !hreadyout |=> hreadyout;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("wait state longer than one");
  property p_wait_cause;
    @(posedge hclk) disable iff (!hresetn)
      $fell(hreadyout) |-> $past(hsel) && !$past(hwrite);
  endproperty
  a_wait_cause: assert property (p_wait_cause)
    else $error("wait state without a read");
  property p_rdata_hold;
    @(posedge hclk) disable iff (!hresetn)
      $changed(hrdata) |-> $past(hreadyout) == 1'b0;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved outside a read");
  property p_close_pulse;
    @(posedge hclk) disable iff (!hresetn) dma_close |=> !dma_close;
  endproperty
  a_close_pulse: assert property (p_close_pulse)
    else $error("close pulse too long");
  property p_frame;
    @(posedge link_clk) disable iff (!hresetn)
      $fell(spi_cs_n) |-> !spi_cs_n [*8];
  endproperty
  a_frame: assert property (p_frame)
    else $error("select dropped before a whole byte");
endmodule : qss_status_monitor
bind qss_top qss_status_monitor MON (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk),
  .dma_close(dma_close), .spi_cs_n(spi_cs_n)
);

/* File: tb/qss_spi_slave_model.sv */
`timescale 1ns/10ps
module qss_spi_slave_model (
  input  wire logic link_en,
  input  wire logic spi_cs_n,
  output logic      link_clk
);
  // Clock runs while link_en is set or while selected, else stands still low
  initial begin
    link_clk = 1'b0;
    #7;
    forever begin
      #62.5;
      if (link_en || !spi_cs_n) link_clk = ~link_clk;
      else link_clk = 1'b0;
    end
  end
endmodule : qss_spi_slave_model

/* File: tb/spi_master_status_and_counts_test.sv */
`timescale 1ns/10ps
`include "qss_consts.svh"
module spi_master_status_and_counts_test;
  logic hclk, hresetn, hsel, hwrite, link_en, dma_ack, tx_kick;
  logic [31:0] haddr, hwdata, last_rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic dma_tx_done, dma_rx_done, desc_done, desc_last, rd_dp;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [15:0] nb;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, dma_close, spi_cs_n, link_clk;
  int err_count, checked, seed;
  qss_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk),
    .dma_tx_done(dma_tx_done), .dma_rx_done(dma_rx_done),
    .desc_done(desc_done), .desc_last(desc_last),
    .dma_close(dma_close), .spi_cs_n(spi_cs_n));
  qss_spi_slave_model PEER (.link_en(link_en), .spi_cs_n(spi_cs_n),
    .link_clk(link_clk));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // DMA side answers a close with its done pulse
  always @(posedge hclk)
    dma_tx_done <= tx_kick | (dma_close & dma_ack);
  task automatic give_verdict();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, input logic chk);
    logic r;
    if (!w) exp_q.push_back({chk, d});
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'h2;
    hwrite <= w; hsize <= 3'h2;
    do begin @(negedge hclk); r = hreadyout; @(posedge hclk); end
    while (r !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do begin
      @(negedge hclk); r = hreadyout; last_rd = hrdata; @(posedge hclk);
    end while (r !== 1'b1);
  endtask : bus
  task automatic wait_stat(input logic [31:0] m);
    for (int i = 0; i < 400; i++) begin
      bus(`QSS_OFF_STAT, 1'b0, 32'h0, 1'b0);
      if ((last_rd & m) === m) break;
    end
  endtask : wait_stat
  task automatic pulse(input logic [3:0] s);
    @(posedge hclk);
    {desc_last, desc_done, dma_rx_done, tx_kick} <= s;
    @(posedge hclk);
    {desc_last, desc_done, dma_rx_done, tx_kick} <= 4'h0;
  endtask : pulse
  // Result watcher pops one note per completed read
  always @(posedge hclk)
    if (!hresetn) rd_dp <= 1'b0;
    else if (hsel && htrans[1] && hreadyout && !hwrite) rd_dp <= 1'b1;
    else if (hreadyout) rd_dp <= 1'b0;
  always @(negedge hclk)
    if (rd_dp && hreadyout === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[32]) cmp(hrdata, e[31:0]);
    end
  initial begin
    #1ms;
    err_count++;
    give_verdict();
  end
  initial begin
    {hsel, hwrite, tx_kick, dma_ack, hresetn} = 5'h00;
    {dma_rx_done, desc_done, desc_last} = 3'h0;
    haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0; hsize = 3'h2;
    link_en = 1'b1;
    seed = $urandom(76);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    link_en <= 1'b0;
    bus(`QSS_OFF_STAT, 1'b0, 32'h0, 1'b1);
    bus(`QSS_OFF_CNT, 1'b0, 32'h0, 1'b1);
    repeat (8) bus(`QSS_OFF_TXWR, 1'b1, $urandom, 1'b0);
    bus(`QSS_OFF_CNT, 1'b0, 32'h8, 1'b1);
    bus(`QSS_OFF_STAT, 1'b0, 32'h100, 1'b1);
    bus(`QSS_OFF_TXWR, 1'b1, $urandom, 1'b0);
    bus(`QSS_OFF_STAT, 1'b0, 32'h104, 1'b1);
    bus(`QSS_OFF_STAT, 1'b1, 32'h0, 1'b0);
    bus(`QSS_OFF_STAT, 1'b0, 32'h104, 1'b1);
    bus(`QSS_OFF_STAT, 1'b1, 32'h4, 1'b0);
    bus(`QSS_OFF_STAT, 1'b0, 32'h100, 1'b1);
    bus(8'hF0, 1'b0, 32'h0, 1'b1);
    nb = 16'($urandom_range(7, 1));
    link_en <= 1'b1;
    bus(`QSS_OFF_LEN, 1'b1, {16'h0000, nb}, 1'b0);
    bus(`QSS_OFF_CTRL, 1'b1, 32'h10, 1'b0);
    wait_stat(32'h1);
    bus(`QSS_OFF_STAT, 1'b0, 32'h1, 1'b1);
    bus(`QSS_OFF_CNT, 1'b0, {nb, 16'h0008 - nb}, 1'b1);
    bus(`QSS_OFF_STAT, 1'b1, 32'h1, 1'b0);
    // Halt long before the programmed length is reached
    bus(`QSS_OFF_LEN, 1'b1, 32'hFF, 1'b0);
    bus(`QSS_OFF_CTRL, 1'b1, 32'h10, 1'b0);
    bus(`QSS_OFF_CTRL, 1'b1, 32'h20, 1'b0);
    wait_stat(32'h1);
    bus(`QSS_OFF_STAT, 1'b0, 32'h1, 1'b1);
    bus(`QSS_OFF_CNT, 1'b0, {nb + 16'h0001, 16'h0007 - nb}, 1'b1);
    bus(`QSS_OFF_STAT, 1'b1, 32'h1, 1'b0);
    link_en <= 1'b0;
    bus(`QSS_OFF_CTRL, 1'b1, 32'h3, 1'b0);
    pulse(4'h1);
    bus(`QSS_OFF_STAT, 1'b0, 32'h0, 1'b1);
    pulse(4'h2);
    bus(`QSS_OFF_STAT, 1'b0, 32'h3, 1'b1);
    bus(`QSS_OFF_STAT, 1'b1, 32'h3, 1'b0);
    bus(`QSS_OFF_CTRL, 1'b1, 32'h0, 1'b0);
    pulse(4'h3);
    bus(`QSS_OFF_STAT, 1'b0, 32'h0, 1'b1);
    bus(`QSS_OFF_CTRL, 1'b1, 32'h5, 1'b0);
    pulse(4'h1);
    bus(`QSS_OFF_STAT, 1'b0, 32'h2, 1'b1);
    pulse(4'h4);
    bus(`QSS_OFF_STAT, 1'b0, 32'h2, 1'b1);
    pulse(4'hC);
    bus(`QSS_OFF_STAT, 1'b0, 32'h3, 1'b1);
    bus(`QSS_OFF_STAT, 1'b1, 32'h3, 1'b0);
    repeat (2) bus(`QSS_OFF_TXWR, 1'b1, $urandom, 1'b0);
    dma_ack <= 1'b1;
    link_en <= 1'b1;
    bus(`QSS_OFF_LEN, 1'b1, 32'h1, 1'b0);
    bus(`QSS_OFF_CTRL, 1'b1, 32'h19, 1'b0);
    wait_stat(32'h3);
    bus(`QSS_OFF_STAT, 1'b0, 32'h3, 1'b1);
    link_en <= 1'b0;
    repeat (4) @(posedge hclk);
    give_verdict();
  end
endmodule : spi_master_status_and_counts_test
